// >>> rtl/sync_slave_pkg.sv
// Constants for the synchronous slave serial port: register map, field positions, reset values, sizes
package sync_slave_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int WORD_W = 9;
    // Register offsets (word index on the plain register port)
    localparam logic [3:0] RX_CTRL_ADDR = 4'h0;
    localparam logic [3:0] TX_CTRL_ADDR = 4'h1;
    localparam logic [3:0] BAUD_CTRL_ADDR = 4'h2;
    localparam logic [3:0] RX_DATA_ADDR = 4'h3;
    localparam logic [3:0] TX_DATA_ADDR = 4'h4;
    localparam logic [3:0] INT_EN_ADDR = 4'h5;
    localparam logic [3:0] FLAG_ADDR = 4'h6;
    localparam logic [3:0] PIN_CTRL0_ADDR = 4'h7;
    localparam logic [3:0] PIN_CTRL1_ADDR = 4'h8;
    // receive_status_control fields
    localparam int PORT_EN_BIT = 7;
    localparam int NINE_RX_BIT = 6;
    localparam int SINGLE_RX_BIT = 5;
    localparam int CONT_RX_BIT = 4;
    localparam int OVERRUN_BIT = 1;
    localparam int NINTH_RX_BIT = 0;
    // transmit_status_control fields
    localparam int CLK_SRC_BIT = 7;
    localparam int TX9_BIT = 6;
    localparam int TXEN_BIT = 5;
    localparam int SYNC_BIT = 4;
    localparam int TRMT_BIT = 1;
    localparam int TX9D_BIT = 0;
    // baud_control field: clock polarity
    localparam int SCKP_BIT = 4;
    // Interrupt enable and flag fields
    localparam int GLOBAL_IE_BIT = 7;
    localparam int PERIPH_IE_BIT = 6;
    localparam int RX_IE_BIT = 5;
    localparam int TX_IE_BIT = 4;
    localparam int RX_FLAG_BIT = 5;
    localparam int TX_FLAG_BIT = 4;
    // Alternate pin control fields
    localparam int DATA_SEL_BIT = 7;
    localparam int CLK_SEL_BIT = 0;
    // Word lengths as last bit index
    localparam logic [3:0] LAST8 = 4'h7;
    localparam logic [3:0] LAST9 = 4'h8;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
endpackage

// >>> rtl/sync_slave_serial_port.sv
// Synchronous slave serial transceiver: register port, external-clock shift logic, receive FIFO
//
// Contract
// - Nine-bit option receives a ninth bit, shown in the status ninth-data field.
// - Words are accepted only while continuous receive is enabled.
// - Each received word sets receive-complete; interrupt only with receive enable.
// - Low eight bits go through a receive FIFO read via receive data.
// - Clearing continuous receive or port enable clears overrun; port enable resets port.
// - Port runs during sleep only in synchronous slave mode.
// - Both shift registers clocked solely by the external clock pin.
// - During sleep a completed received word sets the flag and wakes.
// - Reading receive data unloads it; flag clears when nothing pending.
// - After wake execution resumes; with global enable the service routine runs.
// - Writing transmit buffer clears empty flag; two writes fill shift and buffer.
// - During sleep transmit data shifts out with external clocks.
// - After shift register empties, buffer moves in, empty flag sets, wakes.
// - Buffer then accepts a new character, clearing the empty flag again.
// - Transmit wake needs transmit and peripheral interrupt enables.
// - Clock and data pins relocate by two alternate pin control registers.
// - With both receive enables clear the port transmits; it receives only with continuous receive set.
module sync_slave_serial_port (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic sleep_i,
    input wire logic serial_clock_pin_pri_i,
    input wire logic serial_clock_pin_alt_i,
    input wire logic serial_data_pin_pri_i,
    input wire logic serial_data_pin_alt_i,
    output logic serial_data_pin_pri_o,
    output logic serial_data_pin_pri_oe_o,
    output logic serial_data_pin_alt_o,
    output logic serial_data_pin_alt_oe_o,
    output logic wake_o,
    output logic int_req_o
);
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic [3:0] pin_meta_ff;
    logic [3:0] pin_sync_ff;
    logic ck_prev_ff;
    logic [7:0] rx_ctrl_ff;
    logic [7:0] tx_ctrl_ff;
    logic [7:0] baud_ctrl_ff;
    logic [7:0] int_en_ff;
    logic [7:0] pin_ctrl0_ff;
    logic [7:0] pin_ctrl1_ff;
    logic [8:0] rx_shift_ff;
    logic [3:0] rx_cnt_ff;
    logic overrun_ff;
    logic [8:0] fifo_ff [0:1];
    logic wr_ptr_ff;
    logic rd_ptr_ff;
    logic [1:0] fifo_cnt_ff;
    logic [8:0] txbuf_ff;
    logic [8:0] tx_shift_ff;
    logic txbuf_full_ff;
    logic tx_shift_full_ff;
    logic [3:0] tx_cnt_ff;
    logic [7:0] rdata_ff;
    logic data_out_ff;
    logic data_pri_oe_ff;
    logic data_alt_oe_ff;
    logic wake_ff;
    logic int_req_ff;

    wire rst_n = rst_sync_ff;

    // Reset release through two flops
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // Pins cross into sys_clk through two flops; only the second stage is read
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_ff <= 4'h0;
            pin_sync_ff <= 4'h0;
        end else begin
            pin_meta_ff <= {serial_data_pin_alt_i, serial_data_pin_pri_i,
                            serial_clock_pin_alt_i, serial_clock_pin_pri_i};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // Control fields
    wire port_en = rx_ctrl_ff[sync_slave_pkg::PORT_EN_BIT];
    wire nine_rx = rx_ctrl_ff[sync_slave_pkg::NINE_RX_BIT];
    wire single_rx = rx_ctrl_ff[sync_slave_pkg::SINGLE_RX_BIT];
    wire cont_rx = rx_ctrl_ff[sync_slave_pkg::CONT_RX_BIT];
    wire clk_src = tx_ctrl_ff[sync_slave_pkg::CLK_SRC_BIT];
    wire tx9 = tx_ctrl_ff[sync_slave_pkg::TX9_BIT];
    wire txen = tx_ctrl_ff[sync_slave_pkg::TXEN_BIT];
    wire sync_mode = tx_ctrl_ff[sync_slave_pkg::SYNC_BIT];
    wire tx9d = tx_ctrl_ff[sync_slave_pkg::TX9D_BIT];
    wire sckp = baud_ctrl_ff[sync_slave_pkg::SCKP_BIT];
    wire global_ie = int_en_ff[sync_slave_pkg::GLOBAL_IE_BIT];
    wire periph_ie = int_en_ff[sync_slave_pkg::PERIPH_IE_BIT];
    wire rx_ie = int_en_ff[sync_slave_pkg::RX_IE_BIT];
    wire tx_ie = int_en_ff[sync_slave_pkg::TX_IE_BIT];

    wire data_sel = pin_ctrl0_ff[sync_slave_pkg::DATA_SEL_BIT];
    wire clk_sel = pin_ctrl1_ff[sync_slave_pkg::CLK_SEL_BIT];
    wire ck_pol = (clk_sel ? pin_sync_ff[1] : pin_sync_ff[0]) ^ sckp;
    wire din = data_sel ? pin_sync_ff[3] : pin_sync_ff[2];
    wire ck_fall = ck_prev_ff & ~ck_pol;

    // only slave mode with external clock runs; no sys-clock shift source exists
    wire slave = port_en & sync_mode & ~clk_src;
    wire rx_mode = single_rx | cont_rx;
    wire rx_run = slave & cont_rx;
    wire tx_run = slave & ~rx_mode & txen;

    // Bus decode
    wire wr_rx_ctrl = wr_i & (addr_i == sync_slave_pkg::RX_CTRL_ADDR);
    wire wr_tx_ctrl = wr_i & (addr_i == sync_slave_pkg::TX_CTRL_ADDR);
    wire wr_baud = wr_i & (addr_i == sync_slave_pkg::BAUD_CTRL_ADDR);
    wire wr_txdata = wr_i & (addr_i == sync_slave_pkg::TX_DATA_ADDR) & port_en;
    wire wr_int_en = wr_i & (addr_i == sync_slave_pkg::INT_EN_ADDR);
    wire wr_pin0 = wr_i & (addr_i == sync_slave_pkg::PIN_CTRL0_ADDR);
    wire wr_pin1 = wr_i & (addr_i == sync_slave_pkg::PIN_CTRL1_ADDR);

    // Receive datapath
    wire fifo_empty = (fifo_cnt_ff == 2'h0);
    wire fifo_full = (fifo_cnt_ff == sync_slave_pkg::FIFO_DEPTH);
    wire [8:0] fifo_head = fifo_ff[rd_ptr_ff];
    wire [3:0] rx_last = nine_rx ? sync_slave_pkg::LAST9 : sync_slave_pkg::LAST8;
    wire rx_done = rx_run & ck_fall & (rx_cnt_ff == rx_last);
    wire [8:0] rx_word = rx_shift_ff | 9'({8'h00, din} << rx_cnt_ff);
    wire rx_push = rx_done & ~fifo_full & ~overrun_ff;
    wire rx_overrun = rx_done & (fifo_full | overrun_ff);
    wire rd_rxdata = rd_i & (addr_i == sync_slave_pkg::RX_DATA_ADDR);
    wire rx_pop = rd_rxdata & ~fifo_empty;
    wire rx_flag = ~fifo_empty;

    // Transmit datapath
    wire [3:0] tx_last = tx9 ? sync_slave_pkg::LAST9 : sync_slave_pkg::LAST8;
    wire tx_shift = tx_run & tx_shift_full_ff & ck_fall;
    wire tx_end = tx_shift & (tx_cnt_ff == tx_last);
    wire tx_load = tx_run & ~tx_shift_full_ff & txbuf_full_ff;
    wire tx_flag = ~txbuf_full_ff;
    wire trmt = ~tx_shift_full_ff;

    // Interrupt sources
    // receive interrupt gated by its enable
    wire rx_int = rx_flag & rx_ie;
    wire tx_int = tx_flag & tx_ie & periph_ie;

    wire [7:0] rx_ctrl_rd = {rx_ctrl_ff[7:4], 2'b00, overrun_ff, fifo_head[8] & rx_flag};
    wire [7:0] tx_ctrl_rd = {tx_ctrl_ff[7:2], trmt, tx_ctrl_ff[0]};
    wire [7:0] flag_rd = {2'b00, rx_flag, tx_flag, 4'h0};
    wire [7:0] rd_mux = (addr_i == sync_slave_pkg::RX_CTRL_ADDR) ? rx_ctrl_rd :
                        (addr_i == sync_slave_pkg::TX_CTRL_ADDR) ? tx_ctrl_rd :
                        (addr_i == sync_slave_pkg::BAUD_CTRL_ADDR) ? baud_ctrl_ff :
                        (addr_i == sync_slave_pkg::RX_DATA_ADDR) ? fifo_head[7:0] :
                        (addr_i == sync_slave_pkg::INT_EN_ADDR) ? int_en_ff :
                        (addr_i == sync_slave_pkg::FLAG_ADDR) ? flag_rd :
                        (addr_i == sync_slave_pkg::PIN_CTRL0_ADDR) ? pin_ctrl0_ff :
                        (addr_i == sync_slave_pkg::PIN_CTRL1_ADDR) ? pin_ctrl1_ff :
                        sync_slave_pkg::READ_ZERO;

    // Software registers; status bits read back from logic, not stored here
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_ctrl_ff <= sync_slave_pkg::CTRL_RST;
            tx_ctrl_ff <= sync_slave_pkg::CTRL_RST;
            baud_ctrl_ff <= sync_slave_pkg::CTRL_RST;
            int_en_ff <= sync_slave_pkg::CTRL_RST;
            pin_ctrl0_ff <= sync_slave_pkg::CTRL_RST;
            pin_ctrl1_ff <= sync_slave_pkg::CTRL_RST;
        end else begin
            if (wr_rx_ctrl) rx_ctrl_ff <= {wdata_i[7:4], 4'h0};
            if (wr_tx_ctrl) tx_ctrl_ff <= {wdata_i[7:2], 1'b0, wdata_i[0]};
            if (wr_baud) baud_ctrl_ff <= wdata_i & 8'h10;
            if (wr_int_en) int_en_ff <= wdata_i & 8'hF0;
            if (wr_pin0) pin_ctrl0_ff <= wdata_i & 8'h80;
            if (wr_pin1) pin_ctrl1_ff <= wdata_i & 8'h01;
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) rdata_ff <= sync_slave_pkg::READ_ZERO;
        else rdata_ff <= rd_i ? rd_mux : sync_slave_pkg::READ_ZERO;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) ck_prev_ff <= 1'b0;
        else ck_prev_ff <= ck_pol;
    end

    // receive shift, sampled on the master's falling edge
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_shift_ff <= 9'h000;
            rx_cnt_ff <= 4'h0;
        end else if (!rx_run || rx_done) begin
            rx_shift_ff <= 9'h000;
            rx_cnt_ff <= 4'h0;
        end else if (ck_fall) begin
            rx_shift_ff <= rx_word;
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
        end
    end

    // overrun cleared by either enable; set wins over nothing since clear is a level
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) overrun_ff <= 1'b0;
        else if (!cont_rx || !port_en) overrun_ff <= 1'b0;
        else if (rx_overrun) overrun_ff <= 1'b1;
    end

    // two-word receive FIFO, ninth bit stored beside the byte
    always_ff @(posedge sys_clk_i) begin
        if (rx_push) fifo_ff[wr_ptr_ff] <= nine_rx ? rx_word : {1'b0, rx_word[7:0]};
    end

    // port enable low clears the FIFO
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            fifo_cnt_ff <= 2'h0;
        end else if (!port_en) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            fifo_cnt_ff <= 2'h0;
        end else begin
            if (rx_push) wr_ptr_ff <= ~wr_ptr_ff;
            if (rx_pop) rd_ptr_ff <= ~rd_ptr_ff;
            fifo_cnt_ff <= fifo_cnt_ff + {1'b0, rx_push} - {1'b0, rx_pop};
        end
    end

    // transmit buffer; a write while loading keeps it full
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            txbuf_ff <= 9'h000;
            txbuf_full_ff <= 1'b0;
        end else if (!port_en) begin
            txbuf_full_ff <= 1'b0;
        end else if (wr_txdata) begin
            txbuf_ff <= {tx9d, wdata_i};
            txbuf_full_ff <= 1'b1;
        end else if (tx_load) begin
            txbuf_full_ff <= 1'b0;
        end
    end

    // shift register advances on the master's sample edge, reloads when empty
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_shift_ff <= 9'h000;
            tx_shift_full_ff <= 1'b0;
            tx_cnt_ff <= 4'h0;
        end else if (!port_en) begin
            tx_shift_full_ff <= 1'b0;
            tx_cnt_ff <= 4'h0;
        end else if (tx_load) begin
            tx_shift_ff <= txbuf_ff;
            tx_shift_full_ff <= 1'b1;
            tx_cnt_ff <= 4'h0;
        end else if (tx_end) begin
            tx_shift_full_ff <= 1'b0;
            tx_cnt_ff <= 4'h0;
        end else if (tx_shift) begin
            tx_shift_ff <= {1'b0, tx_shift_ff[8:1]};
            tx_cnt_ff <= tx_cnt_ff + 4'h1;
        end
    end

    // Pin drive and wake outputs are registered so glitches never reach the pads
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            data_out_ff <= 1'b0;
            data_pri_oe_ff <= 1'b0;
            data_alt_oe_ff <= 1'b0;
            wake_ff <= 1'b0;
            int_req_ff <= 1'b0;
        end else begin
            data_out_ff <= tx_shift_ff[0];
            data_pri_oe_ff <= tx_run & ~data_sel;
            data_alt_oe_ff <= tx_run & data_sel;
            wake_ff <= sleep_i & (rx_int | tx_int);
            // service request only with global enable
            int_req_ff <= global_ie & (rx_int | tx_int);
        end
    end

    assign rdata_o = rdata_ff;
    assign serial_data_pin_pri_o = data_out_ff;
    assign serial_data_pin_alt_o = data_out_ff;
    assign serial_data_pin_pri_oe_o = data_pri_oe_ff;
    assign serial_data_pin_alt_oe_o = data_alt_oe_ff;
    assign wake_o = wake_ff;
    assign int_req_o = int_req_ff;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n);

    sequence tx_last_edge_s;
        tx_end & txbuf_full_ff & ~wr_rx_ctrl & ~wr_tx_ctrl;
    endsequence
    sequence tx_reload_s;
        ~tx_shift_full_ff ##1 (tx_shift_full_ff & (tx_flag | $past(wr_txdata)));
    endsequence
    sequence rx_read_s;
        rd_rxdata & ~fifo_empty;
    endsequence

    rx_flag_set_a: assert property (rx_push |=> rx_flag)
        else $error("receive flag not set after word");
    rx_ninth_a: assert property ((rx_done & nine_rx & fifo_empty & ~overrun_ff & ~rx_pop) |=> fifo_head[8] == $past(din))
        else $error("ninth bit not stored");
    rx_gate_a: assert property (~rx_run |=> rx_cnt_ff == 4'h0 && !rx_push)
        else $error("reception without continuous enable");
    rx_unload_a: assert property ((fifo_cnt_ff == 2'h1 & rx_pop & ~rx_push) |=> ~rx_flag)
        else $error("flag stays after last read");
    overrun_clear_a: assert property ((~cont_rx | ~port_en) |=> ~overrun_ff)
        else $error("overrun not cleared");
    port_reset_a: assert property (~port_en |=> fifo_empty && !tx_shift_full_ff && tx_flag)
        else $error("port enable low did not reset");
    overrun_hold_a: assert property ((rx_done & fifo_full & ~rx_pop & cont_rx & port_en) |=> overrun_ff ##1 (overrun_ff || !cont_rx || !port_en))
        else $error("overrun not flagged");
    shift_edge_a: assert property ((tx_shift_full_ff & ~ck_fall & ~tx_load & port_en) |=> $stable(tx_shift_ff))
        else $error("shift without external edge");
    tx_reload_a: assert property (tx_last_edge_s |=> tx_reload_s)
        else $error("buffer not moved to shift register");
    tx_flag_clear_a: assert property (wr_txdata |=> ~tx_flag)
        else $error("buffer empty flag not cleared");
    tx_wake_a: assert property ((sleep_i & tx_flag & tx_ie & periph_ie) |=> wake_o)
        else $error("transmit wake missing");
    rx_wake_a: assert property ((sleep_i & rx_flag & rx_ie) |=> wake_o ##0 int_req_o == $past(global_ie))
        else $error("receive wake missing");
    rx_read_a: assert property (rx_read_s |=> rdata_o == $past(fifo_head[7:0]))
        else $error("receive data not returned");
    rdata_idle_a: assert property (~rd_i |=> rdata_o == sync_slave_pkg::READ_ZERO)
        else $error("read data outside read cycle");
    tx_load_a: assert property (tx_load |=> tx_shift_full_ff && tx_shift_ff == $past(txbuf_ff))
        else $error("buffer word not loaded");
    tx_bit_a: assert property ((tx_shift & ~tx_end) |=> tx_shift_ff == {1'b0, $past(tx_shift_ff[8:1])})
        else $error("transmit bit not advanced");
    data_oe_a: assert property (~tx_run |=> !serial_data_pin_pri_oe_o && !serial_data_pin_alt_oe_o)
        else $error("data pin driven while not transmitting");
    pin_route_a: assert property ((tx_run & data_sel) |=> serial_data_pin_alt_oe_o && !serial_data_pin_pri_oe_o)
        else $error("data drive on wrong pin");
    awake_a: assert property (~sleep_i |=> ~wake_o)
        else $error("wake raised while awake");
endmodule

// >>> testbench/serial_master_model.sv
// Behavioural external master that drives the shift clock and the data line
module serial_master_model (
    input wire logic data_i,
    output logic clk_o,
    output logic data_o,
    output logic data_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        clk_o = 1'b1;
        data_o = 1'b0;
        data_oe_o = 1'b0;
    end
    // word clocked LSB first, data set in high phase, shift on falling edge
    task automatic xfer(input int n, input logic drive, input logic [8:0] tx, output logic [8:0] rx);
        rx = 9'h000;
        #37;
        for (int i = 0; i < n; i++) begin
            data_oe_o = drive;
            data_o = tx[i];
            #390;
            rx[i] = data_i;
            #10;
            clk_o = 1'b0;
            #400;
            clk_o = 1'b1;
        end
        data_oe_o = 1'b0;
        // Idle tail lets the port finish its last shift before software looks
        #1000;
    endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the synchronous slave serial port
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sleep = 1'b0;
    logic alt_sel = 1'b0;
    logic idle_d = 1'b0;
    logic [7:0] rdata;
    logic [8:0] word;
    logic d_pri_o, d_pri_oe, d_alt_o, d_alt_oe, wake, int_req;
    wire m_clk, m_d, m_oe, line;
    int error_cnt = 0;
    int comparisons = 0;
    // Released line toggles every cycle so a stale value never passes
    assign line = (alt_sel ? d_alt_oe : d_pri_oe) ? (alt_sel ? d_alt_o : d_pri_o) : (m_oe ? m_d : idle_d);
    sync_slave_serial_port u_sync_slave_serial_port (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .addr_i(addr),
        .wdata_i(wdata),
        .wr_i(wr),
        .rd_i(rd),
        .rdata_o(rdata),
        .sleep_i(sleep),
        .serial_clock_pin_pri_i(alt_sel ? 1'b1 : m_clk),
        .serial_clock_pin_alt_i(alt_sel ? m_clk : 1'b1),
        .serial_data_pin_pri_i(alt_sel ? idle_d : line),
        .serial_data_pin_alt_i(alt_sel ? line : idle_d),
        .serial_data_pin_pri_o(d_pri_o),
        .serial_data_pin_pri_oe_o(d_pri_oe),
        .serial_data_pin_alt_o(d_alt_o),
        .serial_data_pin_alt_oe_o(d_alt_oe),
        .wake_o(wake),
        .int_req_o(int_req)
    );
    serial_master_model u_serial_master_model (
        .data_i(line),
        .clk_o(m_clk),
        .data_o(m_d),
        .data_oe_o(m_oe)
    );
    always #50 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) idle_d <= ~idle_d;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask
    task automatic expect_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        @(negedge sys_clk_i);
        check(rdata, exp);
    endtask
    // Wake and interrupt request, packed as {wake, request}
    task automatic expect_pins(input logic [1:0] exp);
        @(negedge sys_clk_i);
        @(negedge sys_clk_i);
        check({6'h00, wake, int_req}, {6'h00, exp});
    endtask
    task automatic send(input int n, input logic [8:0] w);
        u_serial_master_model.xfer(n, 1'b1, w, word);
    endtask
    task automatic take(input logic [7:0] exp);
        u_serial_master_model.xfer(8, 1'b0, 9'h000, word);
        check(word[7:0], exp);
    endtask
    task automatic done(input string name);
        $display("Test %s done", name);
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Whole run needs about 100 us; five times that means a hang
    initial begin
        #500000;
        error_cnt++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        stop_test();
    end
    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        expect_reg(sync_slave_pkg::RX_CTRL_ADDR, 8'h00);
        expect_reg(sync_slave_pkg::FLAG_ADDR, 8'h10);
        expect_reg(4'hF, 8'h00);
        expect_pins(2'b00);
        done("reset");
        // sync set, clock source clear, port enabled without continuous receive
        wr_reg(sync_slave_pkg::TX_CTRL_ADDR, 8'h10);
        wr_reg(sync_slave_pkg::RX_CTRL_ADDR, 8'h80);
        send(8, 9'h0A5);
        expect_reg(sync_slave_pkg::FLAG_ADDR, 8'h10);
        wr_reg(sync_slave_pkg::INT_EN_ADDR, 8'hA0);
        wr_reg(sync_slave_pkg::RX_CTRL_ADDR, 8'h90);
        send(8, 9'h0A5);
        expect_reg(sync_slave_pkg::FLAG_ADDR, 8'h30);
        expect_pins(2'b01);
        expect_reg(sync_slave_pkg::RX_DATA_ADDR, 8'hA5);
        expect_reg(sync_slave_pkg::FLAG_ADDR, 8'h10);
        expect_pins(2'b00);
        done("receive");
        wr_reg(sync_slave_pkg::RX_CTRL_ADDR, 8'hD0);
        send(9, 9'h15A);
        expect_reg(sync_slave_pkg::RX_CTRL_ADDR, 8'hD1);
        expect_reg(sync_slave_pkg::RX_DATA_ADDR, 8'h5A);
        done("nine_bit");
        wr_reg(sync_slave_pkg::RX_CTRL_ADDR, 8'h90);
        send(8, 9'h011);
        send(8, 9'h022);
        send(8, 9'h033);
        expect_reg(sync_slave_pkg::RX_CTRL_ADDR, 8'h92);
        expect_reg(sync_slave_pkg::RX_DATA_ADDR, 8'h11);
        expect_reg(sync_slave_pkg::RX_DATA_ADDR, 8'h22);
        wr_reg(sync_slave_pkg::RX_CTRL_ADDR, 8'h80);
        expect_reg(sync_slave_pkg::RX_CTRL_ADDR, 8'h80);
        expect_reg(sync_slave_pkg::FLAG_ADDR, 8'h10);
        wr_reg(sync_slave_pkg::RX_CTRL_ADDR, 8'h90);
        send(8, 9'h044);
        wr_reg(sync_slave_pkg::RX_CTRL_ADDR, 8'h00);
        expect_reg(sync_slave_pkg::FLAG_ADDR, 8'h10);
        done("overrun");
        wr_reg(sync_slave_pkg::RX_CTRL_ADDR, 8'h90);
        wr_reg(sync_slave_pkg::INT_EN_ADDR, 8'h20);
        @(posedge sys_clk_i);
        sleep <= 1'b1;
        send(8, 9'h069);
        expect_pins(2'b10);
        wr_reg(sync_slave_pkg::INT_EN_ADDR, 8'hA0);
        expect_pins(2'b11);
        expect_reg(sync_slave_pkg::RX_DATA_ADDR, 8'h69);
        expect_pins(2'b00);
        done("sleep_receive");
        // both receive enables cleared selects the transmitter
        wr_reg(sync_slave_pkg::RX_CTRL_ADDR, 8'h80);
        wr_reg(sync_slave_pkg::TX_CTRL_ADDR, 8'h30);
        wr_reg(sync_slave_pkg::INT_EN_ADDR, 8'h10);
        wr_reg(sync_slave_pkg::TX_DATA_ADDR, 8'hC3);
        wr_reg(sync_slave_pkg::TX_DATA_ADDR, 8'h3C);
        expect_reg(sync_slave_pkg::FLAG_ADDR, 8'h00);
        take(8'hC3);
        expect_reg(sync_slave_pkg::FLAG_ADDR, 8'h10);
        expect_pins(2'b00);
        wr_reg(sync_slave_pkg::INT_EN_ADDR, 8'h50);
        expect_pins(2'b10);
        wr_reg(sync_slave_pkg::TX_DATA_ADDR, 8'h77);
        expect_reg(sync_slave_pkg::FLAG_ADDR, 8'h00);
        expect_pins(2'b00);
        take(8'h3C);
        take(8'h77);
        done("sleep_transmit");
        @(posedge sys_clk_i);
        sleep <= 1'b0;
        wr_reg(sync_slave_pkg::INT_EN_ADDR, 8'h00);
        wr_reg(sync_slave_pkg::PIN_CTRL0_ADDR, 8'h80);
        wr_reg(sync_slave_pkg::PIN_CTRL1_ADDR, 8'h01);
        @(posedge sys_clk_i);
        alt_sel <= 1'b1;
        wr_reg(sync_slave_pkg::RX_CTRL_ADDR, 8'h90);
        send(8, 9'h096);
        expect_reg(sync_slave_pkg::RX_DATA_ADDR, 8'h96);
        done("alternate_pins");
        stop_test();
    end
endmodule
